// ### design/tec_timer_event_counters.sv
// Local design decisions: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module tec_timer_event_counters
    import tec_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [tec_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic counter0_event_pin,
    input wire logic counter1_event_pin,
    input wire logic counter2_event_pin,
    input wire logic counter2_capture_pin,
    output logic [2:0] overflow_pulse
);
    import tec_pkg::*;

    // ==========================================
    // State
    typedef struct packed {
        logic [3:0] osc_count;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] sample;
        logic [3:0] sample_old;
        logic [7:0] timer_mode;
        logic [1:0] timer_flags;
        logic [15:0] counter0;
        logic [15:0] counter1;
        logic [7:0] counter2_control;
        logic [15:0] counter2;
        logic [15:0] reload_capture;
        logic [3:0] port_latch;
        logic power_down;
        logic waitrequest;
        logic [31:0] readdata;
        logic [2:0] overflow;
    } tec_state_type;

    tec_state_type q;
    tec_state_type d;

    logic tick;
    logic [3:0] pin_live;
    logic [3:0] fall;
    logic [1:0] mode [2];
    logic [1:0] run;
    logic [1:0] count_en;
    logic [16:0] step [2];
    logic [8:0] high_step;
    logic [1:0] set_tf;
    logic set_tf2;
    logic set_external_event_flag;
    logic en2;
    logic ext2;
    logic access;

    // ==========================================
    // Helpers

    // One count step of counter 0 or 1; bit 16 is the overflow
    // Prescaled mode leaves low-byte bits 7:5 untouched
    function automatic logic [16:0] count_step(input logic [15:0] v, input logic [1:0] m);
        logic [13:0] n13;
        logic [8:0] lo;
        logic [16:0] r;
        n13 = {1'b0, v[15:8], v[4:0]} + 14'h0001;
        lo = {1'b0, v[7:0]} + 9'h001;
        r = '0;
        case (m)
            MODE_PRESCALED: begin
                r = {n13[13], n13[12:5], v[7:5], n13[4:0]};
            end
            MODE_FULL: begin
                r = {1'b0, v} + 17'h00001;
            end
            MODE_RELOAD8: begin
                r = {lo[8], v[15:8], lo[8] ? v[15:8] : lo[7:0]};
            end
            MODE_SPLIT: begin
                r = {lo[8], v[15:8], lo[7:0]};
            end
            default: begin
                r = {1'b0, v};
            end
        endcase
        return r;
    endfunction

    // Byte-lane merge for registers up to 16 bits
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    function automatic logic [31:0] read_mux(input tec_state_type s, input logic [ADDR_W-1:0] a);
        logic [31:0] r;
        r = '0;
        case (a)
            OFS_TIMER_MODE: r[7:0] = s.timer_mode;
            OFS_TIMER_FLAGS: r[1:0] = s.timer_flags;
            OFS_COUNTER0: r[15:0] = s.counter0;
            OFS_COUNTER1: r[15:0] = s.counter1;
            OFS_COUNTER2_CONTROL: r[7:0] = s.counter2_control;
            OFS_COUNTER2: r[15:0] = s.counter2;
            OFS_RELOAD_CAPTURE: r[15:0] = s.reload_capture;
            OFS_PORT_LATCH: r[3:0] = s.port_latch;
            OFS_POWER: r[0] = s.power_down;
            default: r = '0;
        endcase
        return r;
    endfunction

    // ==========================================
    // Next state
    always_comb begin
        d = q;
        d.overflow = '0;
        tick = 1'b0;
        set_tf = '0;
        set_tf2 = 1'b0;
        set_external_event_flag = 1'b0;
        high_step = '0;

        // Machine cycle divider; power-down freezes every count, idle does not
        if (!q.power_down) begin
            if (q.osc_count == CYCLE_LAST) begin
                d.osc_count = '0;
                tick = 1'b1;
            end else begin
                d.osc_count = q.osc_count + 4'h1;
            end
        end

        // Pins: port 3 feeds counters 0 and 1, port 1 feeds counter 2
        d.sync1 = {counter2_capture_pin, counter2_event_pin, counter1_event_pin, counter0_event_pin};
        d.sync2 = q.sync1;
        // A cleared latch bit parks the input high, so no edge is seen
        pin_live = q.sync2 | ~q.port_latch;
        // Sampled once per machine cycle; a level shorter than that may be missed
        if (tick) begin
            d.sample = pin_live;
            d.sample_old = q.sample;
        end
        fall = q.sample_old & ~q.sample & {4{tick}};

        // Counters 0 and 1
        for (int i = 0; i < 2; i++) begin
            mode[i] = q.timer_mode[i*TM_FIELD_W +: 2];
            run[i] = q.timer_mode[i*TM_FIELD_W + TM_RUN];
            count_en[i] = run[i] && (q.timer_mode[i*TM_FIELD_W + TM_SRC] ? fall[i] : tick);
        end
        step[0] = count_step(q.counter0, mode[0]);
        step[1] = count_step(q.counter1, mode[1]);
        if (count_en[0]) begin
            d.counter0 = step[0][15:0];
            set_tf[0] = step[0][16];
        end
        // Counter 1 loses its run bit to the high byte while split, so it holds
        if (mode[0] == MODE_SPLIT) begin
            // High byte runs as a timer under counter 1's run bit
            if (run[1] && tick) begin
                high_step = {1'b0, q.counter0[15:8]} + 9'h001;
                d.counter0[15:8] = high_step[7:0];
                set_tf[1] = high_step[8];
            end
        end else if (count_en[1] && mode[1] != MODE_SPLIT) begin
            d.counter1 = step[1][15:0];
            set_tf[1] = step[1][16];
        end

        // Counter 2
        en2 = q.counter2_control[C2_RUN] &&
              (q.counter2_control[C2_SOURCE] ? fall[PIN_C2] : tick);
        // Capture pin acts even while counter 2 is stopped
        ext2 = fall[PIN_CAP] && q.counter2_control[C2_TRIGGER_EN] &&
               !q.counter2_control[C2_SERIAL_CLOCK];
        if (en2) begin
            if (q.counter2 == 16'hffff) begin
                d.overflow[2] = 1'b1;
                set_tf2 = !q.counter2_control[C2_SERIAL_CLOCK];
                if (q.counter2_control[C2_SERIAL_CLOCK] || !q.counter2_control[C2_CAPTURE]) begin
                    d.counter2 = q.reload_capture;
                end else begin
                    d.counter2 = COUNT_RESET;
                end
            end else begin
                d.counter2 = q.counter2 + 16'h0001;
            end
        end
        if (ext2) begin
            set_external_event_flag = 1'b1;
            if (q.counter2_control[C2_CAPTURE]) begin
                d.reload_capture = q.counter2;
            end else begin
                d.counter2 = q.reload_capture;
            end
        end
        d.overflow[1:0] = set_tf;

        // Bus slave: one wait cycle, then the transfer completes
        // Idle waitrequest high costs a cycle but keeps read data registered
        access = (avs_read || avs_write) && !q.waitrequest;
        if ((avs_read || avs_write) && q.waitrequest) begin
            d.waitrequest = 1'b0;
            d.readdata = read_mux(q, avs_address);
        end else begin
            d.waitrequest = 1'b1;
        end
        if (access && avs_write) begin
            case (avs_address)
                OFS_TIMER_MODE: begin
                    if (avs_byteenable[0]) begin
                        d.timer_mode = avs_writedata[7:0];
                    end
                end
                OFS_TIMER_FLAGS: begin
                    if (avs_byteenable[0]) begin
                        d.timer_flags = q.timer_flags & ~avs_writedata[1:0];
                    end
                end
                OFS_COUNTER0: d.counter0 = merge16(q.counter0, avs_writedata, avs_byteenable);
                OFS_COUNTER1: d.counter1 = merge16(q.counter1, avs_writedata, avs_byteenable);
                OFS_COUNTER2_CONTROL: begin
                    if (avs_byteenable[0]) begin
                        d.counter2_control = avs_writedata[7:0];
                    end
                end
                OFS_COUNTER2: d.counter2 = merge16(q.counter2, avs_writedata, avs_byteenable);
                OFS_RELOAD_CAPTURE: begin
                    d.reload_capture = merge16(q.reload_capture, avs_writedata, avs_byteenable);
                end
                OFS_PORT_LATCH: begin
                    if (avs_byteenable[0]) begin
                        d.port_latch = avs_writedata[3:0];
                    end
                end
                OFS_POWER: begin
                    if (avs_byteenable[0]) begin
                        d.power_down = avs_writedata[0];
                    end
                end
                default: begin
                end
            endcase
        end

        // Hardware sets win over a software clear in the same cycle
        d.timer_flags = d.timer_flags | set_tf;
        if (set_tf2) begin
            d.counter2_control[C2_OVERFLOW_FLAG] = 1'b1;
        end
        if (set_external_event_flag) begin
            d.counter2_control[C2_EVENT_FLAG] = 1'b1;
        end
    end

    // ==========================================
    // Registers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            q.osc_count <= '0;
            // Pin pipeline resets low; a rise is harmless, only falls count
            q.sync1 <= '0;
            q.sync2 <= '0;
            q.sample <= '0;
            q.sample_old <= '0;
            q.timer_mode <= MODE_RESET;
            q.timer_flags <= '0;
            q.counter0 <= COUNT_RESET;
            q.counter1 <= COUNT_RESET;
            q.counter2_control <= MODE_RESET;
            q.counter2 <= COUNT_RESET;
            q.reload_capture <= COUNT_RESET;
            q.port_latch <= PORT_LATCH_RESET;
            q.power_down <= 1'b0;
            q.waitrequest <= 1'b1;
            q.readdata <= '0;
            q.overflow <= '0;
        end else begin
            q <= d;
        end
    end

    assign avs_readdata = q.readdata;
    assign avs_waitrequest = q.waitrequest;
    assign overflow_pulse = q.overflow;
endmodule
`default_nettype wire

// ### design/tec_pkg.sv
// Summary of operation
// - Three independent 16-bit counters for intervals, pulse widths, events and interrupt requests.
// - A machine cycle is six states of two oscillator periods, twelve in all.
// - In timer operation a counter adds one every machine cycle.
// - In event operation a counter adds one per falling input edge, two machine cycles to detect.
// - Counters 0 and 1 are configured separately, each in one of four modes.
// - Mode 0 is an 8-bit counter behind a divide-by-32 prescaler.
// - Mode 1 is a full 16-bit timer or event counter.
// - Mode 2 is an 8-bit counter reloading from the high byte on overflow.
// - Mode 3 splits counter 0 into two separate byte-wide counters.
// - Counter 2 counts machine cycles or events as its source select bit says.
// - Counter 2 offers capture, auto-reload and baud-clock modes set by its control register.
// - In idle the counters keep counting and signalling as normal.
// - In power-down every counter stops and keeps its value.
// - A pin alternate function works only while its port latch bit is one.
// - Counter 0 and 1 event inputs come from port 3 pins.
// - Counter 2 external inputs come from a port 1 pin.
// - Capture mode with trigger enabled copies counter 2 on a capture pin fall and flags it.
// - Auto-reload mode reloads counter 2 on overflow, and on a capture pin fall if enabled.
// - Counter 2 overflow sets a software-cleared flag, never while clocking the serial port.
// - Counter 2 stops when not running; serial clock select forces auto-reload.
`default_nettype none
package tec_pkg;
    // ==========================================
    // Machine cycle timing
    localparam int STATES_PER_CYCLE = 6;
    localparam int OSC_PER_STATE = 2;
    localparam int OSC_PER_CYCLE = STATES_PER_CYCLE * OSC_PER_STATE;
    localparam logic [3:0] CYCLE_LAST = 4'(OSC_PER_CYCLE - 1);

    // ==========================================
    // Register map, byte addresses
    localparam int ADDR_W = 6;
    localparam logic [5:0] OFS_TIMER_MODE = 6'h00;
    localparam logic [5:0] OFS_TIMER_FLAGS = 6'h04;
    localparam logic [5:0] OFS_COUNTER0 = 6'h08;
    localparam logic [5:0] OFS_COUNTER1 = 6'h0c;
    localparam logic [5:0] OFS_COUNTER2_CONTROL = 6'h10;
    localparam logic [5:0] OFS_COUNTER2 = 6'h14;
    localparam logic [5:0] OFS_RELOAD_CAPTURE = 6'h18;
    localparam logic [5:0] OFS_PORT_LATCH = 6'h1c;
    localparam logic [5:0] OFS_POWER = 6'h20;

    // ==========================================
    // Timer mode fields, per counter 4 bits: mode[1:0], source, run
    localparam int TM_FIELD_W = 4;
    localparam int TM_SRC = 2;
    localparam int TM_RUN = 3;
    localparam logic [1:0] MODE_PRESCALED = 2'h0;
    localparam logic [1:0] MODE_FULL = 2'h1;
    localparam logic [1:0] MODE_RELOAD8 = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;

    // ==========================================
    // Counter 2 control fields
    localparam int C2_OVERFLOW_FLAG = 7;
    localparam int C2_EVENT_FLAG = 6;
    localparam int C2_SERIAL_CLOCK = 4;
    localparam int C2_TRIGGER_EN = 3;
    localparam int C2_RUN = 2;
    localparam int C2_SOURCE = 1;
    localparam int C2_CAPTURE = 0;

    // ==========================================
    // Pin indices and reset values
    localparam int PIN_C0 = 0;
    localparam int PIN_C1 = 1;
    localparam int PIN_C2 = 2;
    localparam int PIN_CAP = 3;
    localparam logic [3:0] PORT_LATCH_RESET = 4'hf;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [7:0] MODE_RESET = 8'h00;
endpackage
`default_nettype wire

// ### tb/tec_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tec_checker
    import tec_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [tec_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic counter0_event_pin,
    input wire logic counter1_event_pin,
    input wire logic counter2_event_pin,
    input wire logic counter2_capture_pin,
    input wire logic [2:0] overflow_pulse
);
    import tec_pkg::*;

    // ==========================================
    // Bus and counter properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_done;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    sequence s_rd_ack;
        avs_read && !avs_waitrequest;
    endsequence
    property p_handshake;
        s_req |=> s_done;
    endproperty
    property p_no_spurious;
        $fell(avs_waitrequest) |-> $past(avs_read || avs_write);
    endproperty
    property p_reset_idle;
        $rose(rstn) |-> avs_waitrequest && overflow_pulse == 3'h0;
    endproperty
    // Ticks come every twelve clocks, so overflows can never be closer
    property p_ovf0_gap;
        $rose(overflow_pulse[0]) |=> !overflow_pulse[0] [*8];
    endproperty
    property p_ovf1_gap;
        $rose(overflow_pulse[1]) |=> !overflow_pulse[1] [*8];
    endproperty
    property p_ovf2_gap;
        $rose(overflow_pulse[2]) |=> !overflow_pulse[2] [*8];
    endproperty
    property p_ctrl_width;
        s_rd_ack ##0 (avs_address == OFS_COUNTER2_CONTROL) |-> avs_readdata[31:8] == 24'h0;
    endproperty
    property p_mode_width;
        s_rd_ack ##0 (avs_address == OFS_TIMER_MODE) |-> avs_readdata[31:8] == 24'h0;
    endproperty
    property p_latch_width;
        s_rd_ack ##0 (avs_address == OFS_PORT_LATCH) |-> avs_readdata[31:4] == 28'h0;
    endproperty
    a_handshake: assert property (p_handshake) else $error("bus answer not one wait cycle");
    a_no_spurious: assert property (p_no_spurious) else $error("answer without request");
    a_reset_idle: assert property (p_reset_idle) else $error("outputs busy after reset");
    a_ovf0_gap: assert property (p_ovf0_gap) else $error("counter0 overflows too close");
    a_ovf1_gap: assert property (p_ovf1_gap) else $error("counter1 overflows too close");
    a_ovf2_gap: assert property (p_ovf2_gap) else $error("counter2 overflows too close");
    a_ctrl_width: assert property (p_ctrl_width) else $error("control read too wide");
    a_mode_width: assert property (p_mode_width) else $error("mode read too wide");
    a_latch_width: assert property (p_latch_width) else $error("latch read too wide");
endmodule
bind tec_timer_event_counters tec_checker u_chk (.clock(clock), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .counter0_event_pin(counter0_event_pin),
    .counter1_event_pin(counter1_event_pin), .counter2_event_pin(counter2_event_pin),
    .counter2_capture_pin(counter2_capture_pin), .overflow_pulse(overflow_pulse));
`default_nettype wire

// ### tb/tec_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module tec_pin_model (
    input wire logic clock,
    input wire logic [3:0] fire,
    output logic [3:0] pins
);
    // ==========================================
    // Pin pulse driver
    // Each level lasts 24 clocks: two machine cycles, margin over the minimum
    logic [5:0] left_q [4] = '{6'h00, 6'h00, 6'h00, 6'h00};
    always @(posedge clock) begin
        for (int i = 0; i < 4; i++) begin
            if (fire[i] && left_q[i] == 6'h00) begin
                left_q[i] <= 6'h30;
            end else if (left_q[i] != 6'h00) begin
                left_q[i] <= left_q[i] - 6'h01;
            end
        end
    end
    // Idle pins sit at the pull-up level
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pins[i] = !(left_q[i] > 6'h18);
        end
    end
endmodule
`default_nettype wire

// ### tb/tb_timer_event_counters.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module tb_timer_event_counters;
    import tec_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic avs_waitrequest;
    logic [5:0] avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic [3:0] fire = 4'h0;
    logic [3:0] pins;
    logic [2:0] overflow_pulse;
    logic [31:0] q;
    logic [31:0] a;
    int g;
    int fail_count = 0;
    int checked = 0;
    tec_timer_event_counters dut (.clock(clock), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .counter0_event_pin(pins[PIN_C0]), .counter1_event_pin(pins[PIN_C1]),
        .counter2_event_pin(pins[PIN_C2]), .counter2_capture_pin(pins[PIN_CAP]), .overflow_pulse(overflow_pulse));
    tec_pin_model far_pins (.clock(clock), .fire(fire), .pins(pins));
    initial begin
        forever #5 clock = ~clock;
    end
    // ==========================================
    // Bus and pin tasks
    // Request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr_en, input logic [5:0] adr, input logic [31:0] d);
        @(posedge clock);
        avs_read <= !wr_en;
        avs_write <= wr_en;
        avs_address <= adr;
        avs_writedata <= d;
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // No local limits: a pulse that never comes is left to the watchdog
    task automatic waitp(input int b);
        while (overflow_pulse[b] !== 1'b1) begin
            @(posedge clock);
        end
    endtask
    task automatic gap(input int b);
        waitp(b);
        g = 0;
        do begin
            @(posedge clock);
            g++;
        end while (overflow_pulse[b] !== 1'b1);
    endtask
    task automatic pulse(input int p, input int n);
        repeat (n) begin
            @(posedge clock);
            fire[p] <= 1'b1;
            @(posedge clock);
            fire[p] <= 1'b0;
            repeat (60) @(posedge clock);
        end
    endtask
    task automatic conclude;
        $display("checks %0d, failures %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ==========================================
    // Tests
    initial begin
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        bus(1'b0, OFS_TIMER_MODE, 32'h0); `CHK(q, 32'h0)
        bus(1'b0, OFS_COUNTER0, 32'h0); `CHK(q, 32'h0)
        bus(1'b0, OFS_COUNTER2_CONTROL, 32'h0); `CHK(q, 32'h0)
        bus(1'b0, OFS_PORT_LATCH, 32'h0); `CHK(q, 32'hf)
        bus(1'b0, 6'h3c, 32'h0); `CHK(q, 32'h0)
        $display("test reset done");
        bus(1'b1, OFS_COUNTER0, 32'hfefe);
        bus(1'b1, OFS_TIMER_MODE, 32'h0a);
        gap(0); `CHK(g, 24)
        bus(1'b0, OFS_COUNTER0, 32'h0); `CHK(q[15:8], 8'hfe)
        bus(1'b0, OFS_TIMER_FLAGS, 32'h0); `CHK(q[0], 1'b1)
        bus(1'b1, OFS_TIMER_MODE, 32'h0);
        bus(1'b1, OFS_COUNTER0, 32'hff1f);
        bus(1'b1, OFS_TIMER_MODE, 32'h08);
        waitp(0);
        bus(1'b0, OFS_COUNTER0, 32'h0); `CHK(q[15:8], 8'h00)
        $display("test reload and prescale done");
        bus(1'b1, OFS_TIMER_MODE, 32'h0);
        bus(1'b1, OFS_COUNTER0, 32'h0);
        bus(1'b1, OFS_TIMER_MODE, 32'h09);
        repeat (120) @(posedge clock);
        bus(1'b1, OFS_POWER, 32'h1);
        bus(1'b0, OFS_COUNTER0, 32'h0);
        a = q;
        repeat (100) @(posedge clock);
        bus(1'b0, OFS_COUNTER0, 32'h0); `CHK(q, a)
        `CHK(a > 32'h8 && a < 32'h10, 1'b1)
        bus(1'b1, OFS_POWER, 32'h0);
        $display("test power-down done");
        // Counter1 running but split mode must freeze it
        bus(1'b1, OFS_TIMER_MODE, 32'h0);
        bus(1'b1, OFS_COUNTER0, 32'h0);
        bus(1'b1, OFS_TIMER_MODE, 32'h8b);
        gap(1); `CHK(g, 3072)
        bus(1'b0, OFS_COUNTER1, 32'h0); `CHK(q, 32'h0)
        $display("test split done");
        bus(1'b1, OFS_TIMER_MODE, 32'hd0);
        bus(1'b1, OFS_COUNTER1, 32'h0);
        pulse(1, 3);
        bus(1'b0, OFS_COUNTER1, 32'h0); `CHK(q, 32'h3)
        bus(1'b1, OFS_PORT_LATCH, 32'hd);
        pulse(1, 2);
        bus(1'b0, OFS_COUNTER1, 32'h0); `CHK(q, 32'h3)
        bus(1'b1, OFS_PORT_LATCH, 32'hf);
        bus(1'b1, OFS_TIMER_MODE, 32'h0);
        $display("test events done");
        bus(1'b1, OFS_COUNTER2, 32'hfffe);
        bus(1'b1, OFS_RELOAD_CAPTURE, 32'h1234);
        bus(1'b1, OFS_COUNTER2_CONTROL, 32'h04);
        waitp(2);
        bus(1'b0, OFS_COUNTER2, 32'h0); `CHK(q[15:8], 8'h12)
        bus(1'b0, OFS_COUNTER2_CONTROL, 32'h0); `CHK(q[7], 1'b1)
        bus(1'b1, OFS_COUNTER2_CONTROL, 32'h0);
        bus(1'b1, OFS_COUNTER2, 32'hfffe);
        bus(1'b1, OFS_COUNTER2_CONTROL, 32'h15);
        waitp(2);
        bus(1'b0, OFS_COUNTER2_CONTROL, 32'h0); `CHK(q[7], 1'b0)
        bus(1'b0, OFS_COUNTER2, 32'h0); `CHK(q[15:8], 8'h12)
        bus(1'b1, OFS_COUNTER2_CONTROL, 32'h0);
        bus(1'b1, OFS_COUNTER2, 32'h5600);
        bus(1'b1, OFS_COUNTER2_CONTROL, 32'h0d);
        pulse(3, 1);
        bus(1'b0, OFS_RELOAD_CAPTURE, 32'h0); `CHK(q[15:8], 8'h56)
        bus(1'b0, OFS_COUNTER2_CONTROL, 32'h0); `CHK(q[6], 1'b1)
        // Stopped, reload mode, trigger on: a capture pin fall reloads
        bus(1'b1, OFS_COUNTER2_CONTROL, 32'h08);
        bus(1'b1, OFS_COUNTER2, 32'h0);
        pulse(3, 1);
        bus(1'b0, OFS_COUNTER2, 32'h0); `CHK(q[15:8], 8'h56)
        bus(1'b1, OFS_COUNTER2_CONTROL, 32'h0);
        bus(1'b1, OFS_COUNTER2, 32'h0);
        bus(1'b1, OFS_COUNTER2_CONTROL, 32'h06);
        pulse(2, 2);
        bus(1'b0, OFS_COUNTER2, 32'h0); `CHK(q, 32'h2)
        $display("test counter2 done");
        conclude();
    end
    initial begin
        repeat (60000) @(posedge clock);
        fail_count++;
        conclude();
    end
endmodule
`default_nettype wire
